// *** hazard_pkg.sv ***
package hazard_pkg;

  // ----------------------------------------------------------------
  // Widths and sizes
  // ----------------------------------------------------------------
  localparam int ADDR_W = 32;
  localparam int DATA_W = 32;
  localparam int BE_W = 4;
  localparam int SEQ_W = 6;
  localparam int SQ_DEPTH = 4;
  localparam int SQ_IDX_W = 2;
  localparam int CNT_W = 5;
  localparam int LINE_OFS_W = 5;

  // ----------------------------------------------------------------
  // Timing counts in core cycles
  // ----------------------------------------------------------------
  localparam logic [CNT_W-1:0] BRANCH_PENALTY_CYC = 5'h0C;
  localparam logic [CNT_W-1:0] TAKEN_BUBBLE_CYC = 5'h03;
  localparam logic [CNT_W-1:0] LIKELY_EXTRA_CYC = 5'h02;
  localparam logic [CNT_W-1:0] LOAD_REFETCH_CYC = 5'h0F;

  // ----------------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------------
  localparam logic [ADDR_W-1:0] PC_RESET = 32'h0000_0000;
  localparam logic [DATA_W-1:0] DATA_RESET = 32'h0000_0000;
  localparam logic [BE_W-1:0] BE_NONE = 4'h0;
  localparam logic [BE_W-1:0] BE_ALL = 4'hF;
  localparam logic [CNT_W-1:0] CNT_RESET = 5'h00;

  typedef enum logic [1:0] {F_RUN, F_SLOT, F_BUBBLE, F_PENALTY} fetch_state_t;

  // Word address compare, used by every queue entry and the drain stage
  function automatic logic addr_match(input logic [ADDR_W-1:0] a, input logic [ADDR_W-1:0] b);
    addr_match = (a[ADDR_W-1:2] == b[ADDR_W-1:2]);
  endfunction

  // Sequence numbers wrap; the store is older when the distance is positive
  function automatic logic is_older(input logic [SEQ_W-1:0] st, input logic [SEQ_W-1:0] ld);
    logic [SEQ_W-1:0] d;
    d = ld - st;
    is_older = (d != '0) && !d[SEQ_W-1];
  endfunction

endpackage

// *** sq_if.sv ***
`timescale 1ns/100ps
interface sq_if;
  import hazard_pkg::*;
  logic push;
  logic [ADDR_W-1:0] push_addr;
  logic [DATA_W-1:0] push_data;
  logic [BE_W-1:0] push_be;
  logic [SEQ_W-1:0] push_seq;
  logic grad;
  logic full;
  logic [ADDR_W-1:0] ld_addr;
  logic [SEQ_W-1:0] ld_seq;
  logic [DATA_W-1:0] fwd_data;
  logic [BE_W-1:0] fwd_be;
  logic drain_valid;
  logic pop;
  logic [ADDR_W-1:0] drain_addr;
  logic [DATA_W-1:0] drain_data;
  logic [BE_W-1:0] drain_be;

  modport owner(output push, push_addr, push_data, push_be, push_seq, grad, ld_addr, ld_seq, pop,
    input full, fwd_data, fwd_be, drain_valid, drain_addr, drain_data, drain_be);
  modport queue(input push, push_addr, push_data, push_be, push_seq, grad, ld_addr, ld_seq, pop,
    output full, fwd_data, fwd_be, drain_valid, drain_addr, drain_data, drain_be);
endinterface

// *** store_forward_queue.sv ***
`timescale 1ns/100ps
module store_forward_queue
  import hazard_pkg::*;
(
  input wire logic clk_in,
  input wire logic rst_n_in,
  sq_if.queue q
);

  logic [ADDR_W-1:0] addr [SQ_DEPTH];
  logic [DATA_W-1:0] data [SQ_DEPTH];
  logic [BE_W-1:0] be [SQ_DEPTH];
  logic [SEQ_W-1:0] seq [SQ_DEPTH];
  logic [SQ_DEPTH-1:0] valid, grad;
  logic [SQ_DEPTH-1:0] next_valid, next_grad;
  logic [SQ_IDX_W-1:0] head, tail, gptr, next_head, next_tail, next_gptr;
  logic [SQ_IDX_W:0] count, next_count;
  logic [SQ_DEPTH-1:0] hit;
  logic do_push;

  // ----------------------------------------------------------------
  // Occupancy and graduation
  // ----------------------------------------------------------------
  assign q.full = (count == (SQ_IDX_W+1)'(SQ_DEPTH));
  assign do_push = q.push && !q.full;
  // Only graduated stores leave, head first, so memory sees program order
  assign q.drain_valid = valid[head] && grad[head];
  assign q.drain_addr = addr[head];
  assign q.drain_data = data[head];
  assign q.drain_be = be[head];

  always_comb begin
    next_valid = valid;
    next_grad = grad;
    next_head = head;
    next_tail = tail;
    next_gptr = gptr;
    next_count = count;
    if (do_push) begin
      next_valid[tail] = 1'b1;
      next_grad[tail] = 1'b0;
      next_tail = tail + 1'b1;
    end
    if (q.grad && valid[gptr] && !grad[gptr]) begin
      next_grad[gptr] = 1'b1;
      next_gptr = gptr + 1'b1;
    end
    if (q.pop && q.drain_valid) begin
      next_valid[head] = 1'b0;
      next_head = head + 1'b1;
    end
    next_count = count + (SQ_IDX_W+1)'(do_push) - (SQ_IDX_W+1)'(q.pop && q.drain_valid);
  end

  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      valid <= '0;
      grad <= '0;
      head <= '0;
      tail <= '0;
      gptr <= '0;
      count <= '0;
    end else begin
      valid <= next_valid;
      grad <= next_grad;
      head <= next_head;
      tail <= next_tail;
      gptr <= next_gptr;
      count <= next_count;
    end
  end

  always_ff @(posedge clk_in) begin
    if (do_push) begin
      addr[tail] <= q.push_addr;
      data[tail] <= q.push_data;
      be[tail] <= q.push_be;
      seq[tail] <= q.push_seq;
    end
  end

  // ----------------------------------------------------------------
  // Per-byte forwarding, walked oldest to youngest so the youngest wins
  // ----------------------------------------------------------------
  for (genvar g = 0; g < SQ_DEPTH; g++) begin : g_hit
    assign hit[g] = valid[g] && addr_match(addr[g], q.ld_addr) && is_older(seq[g], q.ld_seq);
  end

  always_comb begin
    logic [SQ_IDX_W-1:0] idx;
    idx = head;
    q.fwd_data = DATA_RESET;
    q.fwd_be = BE_NONE;
    for (int i = 0; i < SQ_DEPTH; i++) begin
      idx = head + SQ_IDX_W'(i);
      for (int b = 0; b < BE_W; b++) begin
        if (hit[idx] && be[idx][b]) begin
          q.fwd_data[b*8 +: 8] = data[idx][b*8 +: 8];
          q.fwd_be[b] = 1'b1;
        end
      end
    end
  end

  a_pop_graduated: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    q.pop && q.drain_valid |-> grad[head] ##1 !valid[$past(head)])
    else $error("store left the queue before graduating");

endmodule

// *** hazard_control.sv ***
`timescale 1ns/100ps
// What this block does
// - The instruction right after any branch always executes, taken or not.
// - Unknown target holds fetch 12 cycles, no flush; misprediction costs at least 12 cycles, flush and refetch.
// - A predicted taken branch leaves three empty fetch cycles after its delay slot.
// - Branch-likely goes through the ordinary prediction path, no special case.
// - Mispredicted branch-likely refetches branch and slot, two extra cycles.
// - Loads never block; only a consumer of missing data waits.
// - A prefetch only brings the line into the data cache.
// - A missing load replays dependents already dispatched on hit timing.
// - Uncached loads count as misses for replay and waiting.
// - Undispatched dependents stay in the dispatch wait queue until data returns.
// - Stores graduate first and never write cache or memory while speculative.
// - Register dependencies are tracked; store-to-load address ones are not.
// - Loads take data from incomplete stores held in the fill store buffer.
// - Loads with all four bytes covered by bypassed store data get it with hit timing.
// - A consumer issued before the miss is known is refetched, about 15 cycles.
module hazard_control
  import hazard_pkg::*;
(
  input wire logic SYS_CLK_IN,
  input wire logic RST_N_IN,
  input wire logic BR_VALID_IN,
  input wire logic BR_TAKEN_PRED_IN,
  input wire logic BR_TARGET_KNOWN_IN,
  input wire logic BR_LIKELY_IN,
  input wire logic BR_RESOLVE_IN,
  input wire logic BR_MISPRED_IN,
  input wire logic [ADDR_W-1:0] BR_PC_IN,
  input wire logic [ADDR_W-1:0] BR_TARGET_IN,
  input wire logic LD_RESULT_IN,
  input wire logic PREF_VALID_IN,
  input wire logic [ADDR_W-1:0] LD_ADDR_IN,
  input wire logic [SEQ_W-1:0] LD_SEQ_IN,
  input wire logic LD_MISS_IN,
  input wire logic LD_UNCACHED_IN,
  input wire logic LD_FILL_IN,
  input wire logic CONS_DISPATCHED_IN,
  input wire logic CONS_ISSUED_IN,
  input wire logic [ADDR_W-1:0] CONS_PC_IN,
  input wire logic [DATA_W-1:0] BUF_DATA_IN,
  input wire logic [BE_W-1:0] BUF_BE_IN,
  input wire logic ST_VALID_IN,
  input wire logic [ADDR_W-1:0] ST_ADDR_IN,
  input wire logic [DATA_W-1:0] ST_DATA_IN,
  input wire logic [BE_W-1:0] ST_BE_IN,
  input wire logic [SEQ_W-1:0] ST_SEQ_IN,
  input wire logic ST_GRAD_IN,
  input wire logic BUF_WR_READY_IN,
  output logic FETCH_HOLD_OUT,
  output logic FLUSH_OUT,
  output logic [ADDR_W-1:0] REFETCH_PC_OUT,
  output logic REPLAY_OUT,
  output logic WAIT_HOLD_OUT,
  output logic LD_FWD_VALID_OUT,
  output logic LD_MISS_OUT,
  output logic [DATA_W-1:0] LD_FWD_DATA_OUT,
  output logic [BE_W-1:0] LD_FWD_BE_OUT,
  output logic PREF_REQ_OUT,
  output logic [ADDR_W-1:0] PREF_LINE_OUT,
  output logic ST_FULL_OUT,
  output logic BUF_WR_VALID_OUT,
  output logic [ADDR_W-1:0] BUF_WR_ADDR_OUT,
  output logic [DATA_W-1:0] BUF_WR_DATA_OUT,
  output logic [BE_W-1:0] BUF_WR_BE_OUT
);

  sq_if sq ();

  store_forward_queue u_queue (
    .clk_in(SYS_CLK_IN),
    .rst_n_in(RST_N_IN),
    .q(sq.queue)
  );

  // ----------------------------------------------------------------
  // Fetch redirect and bubble control
  // ----------------------------------------------------------------
  fetch_state_t state, next_state;
  logic [CNT_W-1:0] cnt, next_cnt;
  logic slot_taken, slot_unknown, next_slot_taken, next_slot_unknown;
  logic next_hold, next_flush;
  logic [ADDR_W-1:0] next_refetch_pc;
  logic mispred, early_refetch, load_missed, covered, load_ok;
  logic [BE_W-1:0] merged_be;
  logic [DATA_W-1:0] merged_data;
  logic stage_hit;
  logic [BE_W-1:0] stage_be;

  assign mispred = BR_RESOLVE_IN && BR_MISPRED_IN;
  assign load_ok = LD_RESULT_IN && !PREF_VALID_IN;
  // A drained store waiting for the buffer is seen by neither the queue nor the buffer
  assign stage_hit = BUF_WR_VALID_OUT && addr_match(BUF_WR_ADDR_OUT, LD_ADDR_IN);
  assign stage_be = stage_hit ? BUF_WR_BE_OUT : BE_NONE;
  assign merged_be = sq.fwd_be | stage_be | BUF_BE_IN;
  assign covered = (merged_be == BE_ALL);
  // Uncached reads take the miss path too; a full bypass hides the miss
  assign load_missed = load_ok && (LD_MISS_IN || LD_UNCACHED_IN) && !covered;
  // Branch redirect is the older event, so it wins over a load refetch
  assign early_refetch = load_missed && CONS_ISSUED_IN && !mispred;

  always_comb begin
    next_state = state;
    next_cnt = cnt;
    next_slot_taken = slot_taken;
    next_slot_unknown = slot_unknown;
    next_hold = FETCH_HOLD_OUT;
    next_flush = 1'b0;
    next_refetch_pc = REFETCH_PC_OUT;
    if (mispred) begin
      next_state = F_PENALTY;
      next_hold = 1'b1;
      next_flush = 1'b1;
      if (BR_LIKELY_IN) begin
        // Branch and slot run again, so restart at the branch itself
        next_refetch_pc = BR_PC_IN;
        next_cnt = BRANCH_PENALTY_CYC + LIKELY_EXTRA_CYC - 1'b1;
      end else begin
        next_refetch_pc = BR_TARGET_IN;
        next_cnt = BRANCH_PENALTY_CYC - 1'b1;
      end
    end else if (early_refetch) begin
      next_state = F_PENALTY;
      next_hold = 1'b1;
      next_flush = 1'b1;
      next_refetch_pc = CONS_PC_IN;
      next_cnt = LOAD_REFETCH_CYC - 1'b1;
    end else begin
      case (state)
        F_RUN: begin
          if (BR_VALID_IN) begin
            // Likely and ordinary branches share the same prediction inputs
            next_state = F_SLOT;
            next_hold = 1'b0;
            next_slot_taken = BR_TAKEN_PRED_IN;
            next_slot_unknown = !BR_TARGET_KNOWN_IN;
          end
        end
        F_SLOT: begin
          if (slot_unknown) begin
            next_state = F_PENALTY;
            next_hold = 1'b1;
            next_cnt = BRANCH_PENALTY_CYC - 1'b1;
          end else if (slot_taken) begin
            next_state = F_BUBBLE;
            next_hold = 1'b1;
            next_cnt = TAKEN_BUBBLE_CYC - 1'b1;
          end else begin
            next_state = F_RUN;
          end
        end
        F_BUBBLE, F_PENALTY: begin
          if (cnt == CNT_RESET) begin
            next_state = F_RUN;
            next_hold = 1'b0;
          end else begin
            next_cnt = cnt - 1'b1;
          end
        end
        default: begin
          next_state = F_RUN;
          next_hold = 1'b0;
        end
      endcase
    end
  end

  always_ff @(posedge SYS_CLK_IN) begin
    if (!RST_N_IN) begin
      state <= F_RUN;
      cnt <= CNT_RESET;
      slot_taken <= 1'b0;
      slot_unknown <= 1'b0;
      FETCH_HOLD_OUT <= 1'b0;
      FLUSH_OUT <= 1'b0;
      REFETCH_PC_OUT <= PC_RESET;
    end else begin
      state <= next_state;
      cnt <= next_cnt;
      slot_taken <= next_slot_taken;
      slot_unknown <= next_slot_unknown;
      FETCH_HOLD_OUT <= next_hold;
      FLUSH_OUT <= next_flush;
      REFETCH_PC_OUT <= next_refetch_pc;
    end
  end

  // ----------------------------------------------------------------
  // Load result, replay and wait; no store address tracking here
  // ----------------------------------------------------------------
  logic next_replay, next_wait, next_fwd_valid, next_miss, next_pref;
  logic [ADDR_W-1:0] next_pref_line;

  assign sq.ld_addr = LD_ADDR_IN;
  assign sq.ld_seq = LD_SEQ_IN;

  always_comb begin
    merged_data = BUF_DATA_IN;
    for (int b = 0; b < BE_W; b++) begin
      if (stage_be[b]) begin
        merged_data[b*8 +: 8] = BUF_WR_DATA_OUT[b*8 +: 8];
      end
      if (sq.fwd_be[b]) begin
        merged_data[b*8 +: 8] = sq.fwd_data[b*8 +: 8];
      end
    end
    next_replay = load_missed && CONS_DISPATCHED_IN && !CONS_ISSUED_IN;
    // A new miss in the fill cycle keeps the wait: set beats clear
    next_wait = load_missed || (WAIT_HOLD_OUT && !LD_FILL_IN);
    next_fwd_valid = load_ok && (merged_be != BE_NONE);
    next_miss = load_missed;
    next_pref = PREF_VALID_IN;
    next_pref_line = {LD_ADDR_IN[ADDR_W-1:LINE_OFS_W], {LINE_OFS_W{1'b0}}};
  end

  always_ff @(posedge SYS_CLK_IN) begin
    if (!RST_N_IN) begin
      REPLAY_OUT <= 1'b0;
      WAIT_HOLD_OUT <= 1'b0;
      LD_FWD_VALID_OUT <= 1'b0;
      LD_MISS_OUT <= 1'b0;
      LD_FWD_DATA_OUT <= DATA_RESET;
      LD_FWD_BE_OUT <= BE_NONE;
      PREF_REQ_OUT <= 1'b0;
      PREF_LINE_OUT <= PC_RESET;
    end else begin
      REPLAY_OUT <= next_replay;
      WAIT_HOLD_OUT <= next_wait;
      LD_FWD_VALID_OUT <= next_fwd_valid;
      LD_MISS_OUT <= next_miss;
      LD_FWD_DATA_OUT <= merged_data;
      LD_FWD_BE_OUT <= merged_be;
      PREF_REQ_OUT <= next_pref;
      PREF_LINE_OUT <= next_pref_line;
    end
  end

  // ----------------------------------------------------------------
  // Store queue feed and drain stage toward the fill store buffer
  // ----------------------------------------------------------------
  logic take, next_wr_valid;

  assign sq.push = ST_VALID_IN;
  assign sq.push_addr = ST_ADDR_IN;
  assign sq.push_data = ST_DATA_IN;
  assign sq.push_be = ST_BE_IN;
  assign sq.push_seq = ST_SEQ_IN;
  assign sq.grad = ST_GRAD_IN;
  // Output stage refills only when empty or accepted, keeping drain order
  assign take = !BUF_WR_VALID_OUT || BUF_WR_READY_IN;
  assign sq.pop = take;
  assign next_wr_valid = take ? sq.drain_valid : BUF_WR_VALID_OUT;

  always_ff @(posedge SYS_CLK_IN) begin
    if (!RST_N_IN) begin
      BUF_WR_VALID_OUT <= 1'b0;
      BUF_WR_ADDR_OUT <= PC_RESET;
      BUF_WR_DATA_OUT <= DATA_RESET;
      BUF_WR_BE_OUT <= BE_NONE;
      ST_FULL_OUT <= 1'b0;
    end else begin
      BUF_WR_VALID_OUT <= next_wr_valid;
      BUF_WR_ADDR_OUT <= take ? sq.drain_addr : BUF_WR_ADDR_OUT;
      BUF_WR_DATA_OUT <= take ? sq.drain_data : BUF_WR_DATA_OUT;
      BUF_WR_BE_OUT <= take ? sq.drain_be : BUF_WR_BE_OUT;
      ST_FULL_OUT <= sq.full;
    end
  end

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  sequence s_accept_taken;
    state == F_RUN && BR_VALID_IN && BR_TAKEN_PRED_IN && BR_TARGET_KNOWN_IN && !mispred
      && !early_refetch;
  endsequence

  sequence s_slot_then_bubble;
    !FETCH_HOLD_OUT ##1 FETCH_HOLD_OUT [*3];
  endsequence

  a_taken_bubble: assert property (@(posedge SYS_CLK_IN) disable iff (!RST_N_IN)
    s_accept_taken |-> ##1 s_slot_then_bubble ##1 (state == F_RUN || state == F_PENALTY))
    else $error("taken branch bubble is not three cycles");

  a_slot_runs: assert property (@(posedge SYS_CLK_IN) disable iff (!RST_N_IN)
    state == F_RUN && BR_VALID_IN && !mispred && !early_refetch |=> !FETCH_HOLD_OUT)
    else $error("delay slot was held back");

  a_likely_same: assert property (@(posedge SYS_CLK_IN) disable iff (!RST_N_IN)
    s_accept_taken and BR_LIKELY_IN |-> ##1 s_slot_then_bubble)
    else $error("likely branch predicted differently");

  a_mispred_penalty: assert property (@(posedge SYS_CLK_IN) disable iff (!RST_N_IN)
    mispred && !BR_LIKELY_IN |-> ##1 (FLUSH_OUT && REFETCH_PC_OUT == $past(BR_TARGET_IN)
      && FETCH_HOLD_OUT) ##11 FETCH_HOLD_OUT)
    else $error("misprediction penalty too short or wrong target");

  a_unknown_target: assert property (@(posedge SYS_CLK_IN) disable iff (!RST_N_IN)
    state == F_RUN && BR_VALID_IN && !BR_TARGET_KNOWN_IN && !mispred && !early_refetch
      |-> ##2 FETCH_HOLD_OUT ##11 FETCH_HOLD_OUT)
    else $error("unknown target penalty too short");

  a_likely_reexec: assert property (@(posedge SYS_CLK_IN) disable iff (!RST_N_IN)
    mispred && BR_LIKELY_IN |-> ##1 REFETCH_PC_OUT == $past(BR_PC_IN) ##13 FETCH_HOLD_OUT)
    else $error("likely misprediction does not restart at the branch");

  a_early_refetch: assert property (@(posedge SYS_CLK_IN) disable iff (!RST_N_IN)
    early_refetch |-> ##1 (FLUSH_OUT && REFETCH_PC_OUT == $past(CONS_PC_IN)) ##14 FETCH_HOLD_OUT)
    else $error("early consumer refetch wrong");

  a_replay_dispatched: assert property (@(posedge SYS_CLK_IN) disable iff (!RST_N_IN)
    load_missed && CONS_DISPATCHED_IN && !CONS_ISSUED_IN |=> REPLAY_OUT && WAIT_HOLD_OUT)
    else $error("dispatched dependent not replayed");

  a_uncached_miss: assert property (@(posedge SYS_CLK_IN) disable iff (!RST_N_IN)
    load_ok && LD_UNCACHED_IN && !covered |=> LD_MISS_OUT && WAIT_HOLD_OUT)
    else $error("uncached load not treated as a miss");

  a_wait_until_fill: assert property (@(posedge SYS_CLK_IN) disable iff (!RST_N_IN)
    WAIT_HOLD_OUT && !LD_FILL_IN |=> WAIT_HOLD_OUT)
    else $error("wait released before load data");

  a_no_block: assert property (@(posedge SYS_CLK_IN) disable iff (!RST_N_IN)
    state == F_RUN && load_missed && !CONS_ISSUED_IN && !BR_VALID_IN && !mispred
      |=> !FETCH_HOLD_OUT)
    else $error("fetch stalled on a load miss");

  a_fwd_hit: assert property (@(posedge SYS_CLK_IN) disable iff (!RST_N_IN)
    load_ok && covered |=> LD_FWD_VALID_OUT && !LD_MISS_OUT && LD_FWD_BE_OUT == BE_ALL)
    else $error("bypassed load not completed as a hit");

  a_pref_quiet: assert property (@(posedge SYS_CLK_IN) disable iff (!RST_N_IN)
    PREF_VALID_IN |=> PREF_REQ_OUT && !LD_FWD_VALID_OUT && !REPLAY_OUT && !LD_MISS_OUT)
    else $error("prefetch had a side effect");

  a_drain_hold: assert property (@(posedge SYS_CLK_IN) disable iff (!RST_N_IN)
    BUF_WR_VALID_OUT && !BUF_WR_READY_IN |=> BUF_WR_VALID_OUT && $stable(BUF_WR_ADDR_OUT))
    else $error("store write changed while stalled");

endmodule

// *** fsb_model.sv ***
`timescale 1ns/100ps
// ----------------------------------------------------------------
// Fill/store buffer seen from the core: one word store, write log
// ----------------------------------------------------------------
module buf_model
  import hazard_pkg::*;
(
  input wire logic clk_in,
  input wire logic rst_n_in,
  input wire logic slow_in,
  input wire logic wr_valid_in,
  input wire logic [ADDR_W-1:0] wr_addr_in,
  input wire logic [DATA_W-1:0] wr_data_in,
  input wire logic [BE_W-1:0] wr_be_in,
  input wire logic [ADDR_W-1:0] ld_addr_in,
  output logic ready_out,
  output logic [DATA_W-1:0] data_out,
  output logic [BE_W-1:0] be_out
);
  logic [ADDR_W-1:0] word_addr;
  logic [DATA_W-1:0] word;
  logic [BE_W-1:0] word_be;
  logic [1:0] ph;
  int n_wr;
  logic [ADDR_W-1:0] log_addr [4];
  logic [DATA_W-1:0] log_data [4];

  // Slow mode accepts one write in four cycles, to stall the drain
  assign ready_out = !slow_in || (ph == 2'h3);
  // A lookup that misses the held word gets no lanes and churning data
  assign be_out = (ld_addr_in[31:2] == word_addr[31:2]) ? word_be : BE_NONE;
  assign data_out = (be_out != BE_NONE) ? word : ~word ^ {30'h0, ph};

  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      ph <= 2'h0;
      word_addr <= 32'hFFFF_FFFC;
      word <= DATA_RESET;
      word_be <= BE_NONE;
      n_wr <= 0;
    end else begin
      ph <= ph + 2'h1;
      if (wr_valid_in && ready_out) begin
        for (int b = 0; b < 4; b++) begin
          if (wr_be_in[b]) word[8*b +: 8] <= wr_data_in[8*b +: 8];
        end
        word_addr <= wr_addr_in;
        word_be <= (wr_addr_in[31:2] == word_addr[31:2]) ? (word_be | wr_be_in) : wr_be_in;
        if (n_wr < 4) begin
          log_addr[n_wr] <= wr_addr_in;
          log_data[n_wr] <= wr_data_in;
        end
        n_wr <= n_wr + 1;
      end
    end
  end
endmodule

// *** test_branch_and_load_store_hazard_control.sv ***
`timescale 1ns/100ps
module test_branch_and_load_store_hazard_control;
  import hazard_pkg::*;
  logic clk = 0, rst_n = 0, bv = 0, btp = 0, btk = 0, blk = 0, brs = 0, bmp = 0, lr = 0, pv = 0;
  logic lm = 0, lu = 0, lf = 0, cd = 0, ci = 0, sv = 0, sg = 0, slow = 0;
  logic [31:0] bpc = '0, btg = '0, la = '0, cpc = '0, sa = '0, sd = '0;
  logic [5:0] ls = '0, ss = '0;
  logic [3:0] sb = '0;
  logic hold, flush, rpl, wh, fv, lmo, prq, sfull, wv, rdy;
  logic [31:0] rpc, fwd, pln, wa, wdt, fd;
  logic [3:0] fbe, wbe, fb;
  int n_mismatch = 0;
  int total_checks = 0;

  hazard_control hazard_control_i (.SYS_CLK_IN(clk), .RST_N_IN(rst_n), .BR_VALID_IN(bv),
    .BR_TAKEN_PRED_IN(btp), .BR_TARGET_KNOWN_IN(btk), .BR_LIKELY_IN(blk), .BR_RESOLVE_IN(brs),
    .BR_MISPRED_IN(bmp), .BR_PC_IN(bpc), .BR_TARGET_IN(btg), .LD_RESULT_IN(lr),
    .PREF_VALID_IN(pv), .LD_ADDR_IN(la), .LD_SEQ_IN(ls), .LD_MISS_IN(lm), .LD_UNCACHED_IN(lu),
    .LD_FILL_IN(lf), .CONS_DISPATCHED_IN(cd), .CONS_ISSUED_IN(ci), .CONS_PC_IN(cpc),
    .BUF_DATA_IN(fd), .BUF_BE_IN(fb), .ST_VALID_IN(sv), .ST_ADDR_IN(sa), .ST_DATA_IN(sd),
    .ST_BE_IN(sb), .ST_SEQ_IN(ss), .ST_GRAD_IN(sg), .BUF_WR_READY_IN(rdy),
    .FETCH_HOLD_OUT(hold), .FLUSH_OUT(flush), .REFETCH_PC_OUT(rpc), .REPLAY_OUT(rpl),
    .WAIT_HOLD_OUT(wh), .LD_FWD_VALID_OUT(fv), .LD_MISS_OUT(lmo), .LD_FWD_DATA_OUT(fwd),
    .LD_FWD_BE_OUT(fbe), .PREF_REQ_OUT(prq), .PREF_LINE_OUT(pln), .ST_FULL_OUT(sfull),
    .BUF_WR_VALID_OUT(wv), .BUF_WR_ADDR_OUT(wa), .BUF_WR_DATA_OUT(wdt), .BUF_WR_BE_OUT(wbe));

  buf_model buf_model_i (.clk_in(clk), .rst_n_in(rst_n), .slow_in(slow), .wr_valid_in(wv),
    .wr_addr_in(wa), .wr_data_in(wdt), .wr_be_in(wbe), .ld_addr_in(la), .ready_out(rdy),
    .data_out(fd), .be_out(fb));

  initial begin
    forever #5 clk = ~clk;
  end

  // ----------------------------------------------------------------
  // Shared tasks
  // ----------------------------------------------------------------
  task automatic conclude;
    if (n_mismatch == 0 && total_checks > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask

  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    total_checks++;
    if (g !== e) begin
      n_mismatch++;
      $display("[ERR] %s expected %h seen %h", nm, e, g);
    end
  endtask

  // Counts the run of hold cycles starting at the current sample point
  task automatic hold_len(output int n);
    n = 0;
    while (hold === 1'b1 && n < 40) begin
      n++;
      @(negedge clk);
    end
  endtask

  task automatic ld(input logic [31:0] a, input logic [5:0] s, input logic m, input logic u,
    input logic d, input logic i);
    @(posedge clk);
    lr <= 1'b1;
    {la, ls, lm, lu, cd, ci, cpc} <= {a, s, m, u, d, i, 32'h0000_0400};
    @(posedge clk);
    {lr, lm, lu, cd, ci} <= 5'h00;
    @(negedge clk);
  endtask

  task automatic fill;
    @(posedge clk);
    lf <= 1'b1;
    @(posedge clk);
    lf <= 1'b0;
    @(negedge clk);
    chk("wait free", 0, wh);
  endtask

  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  task automatic br_case(input logic tk, input logic kn, input logic lk, input int len);
    int n;
    @(posedge clk);
    {bv, btp, btk, blk} <= {1'b1, tk, kn, lk};
    @(posedge clk);
    bv <= 1'b0;
    @(negedge clk);
    chk("slot", 0, hold);
    @(negedge clk);
    hold_len(n);
    chk("bubbles", len, n);
    repeat (2) @(negedge clk);
  endtask

  task automatic mispredict(input logic lk, input logic [31:0] pc, input int len);
    int n;
    @(posedge clk);
    {brs, bmp, blk, bpc, btg} <= {2'h3, lk, 32'h0000_1000, 32'h0000_2000};
    @(posedge clk);
    {brs, bmp} <= 2'h0;
    @(negedge clk);
    chk("flush", 1, flush);
    chk("refetch pc", pc, rpc);
    hold_len(n);
    chk("penalty", len, n);
    chk("flush once", 0, flush);
  endtask

  task automatic miss_wait(input logic u);
    ld(32'h0000_0200, 6'h0A, !u, u, 1'b1, 1'b0);
    chk("miss", 1, lmo);
    chk("replay", 1, rpl);
    chk("wait", 1, wh);
    repeat (6) @(negedge clk);
    chk("wait held", 1, wh);
    chk("no stall", 0, hold);
    chk("replay once", 0, rpl);
    fill();
  endtask

  task automatic early_use;
    int n;
    ld(32'h0000_0300, 6'h0B, 1'b1, 1'b0, 1'b0, 1'b1);
    chk("early flush", 1, flush);
    chk("restart pc", 32'h0000_0400, rpc);
    hold_len(n);
    chk("refetch delay", 15, n);
    fill();
  endtask

  task automatic prefetch;
    @(posedge clk);
    {pv, lr, lm, la} <= {3'h7, 32'h1234_5678};
    @(posedge clk);
    {pv, lr, lm} <= 3'h0;
    @(negedge clk);
    chk("pref req", 1, prq);
    chk("pref line", 32'h1234_5660, pln);
    chk("pref quiet", 0, {lmo, rpl, wh, flush, fv});
  endtask

  task automatic stores;
    @(posedge clk);
    {sv, sa, sd, sb, ss} <= {1'b1, 32'h0000_0100, 32'hAAAA_AAAA, 4'hF, 6'h01};
    @(posedge clk);
    {sd, sb, ss} <= {32'hBBBB_0000, 4'hC, 6'h03};
    @(posedge clk);
    sv <= 1'b0;
    ld(32'h0000_0100, 6'h04, 1'b1, 1'b0, 1'b1, 1'b0);
    chk("fwd young", 32'hBBBB_AAAA, fwd);
    chk("fwd lanes", {1'b1, 4'hF, 1'b0}, {fv, fbe, lmo});
    ld(32'h0000_0100, 6'h02, 1'b1, 1'b0, 1'b1, 1'b0);
    chk("fwd older", 32'hAAAA_AAAA, fwd);
    chk("fwd hit", 0, {lmo, rpl, wh});
    repeat (4) @(negedge clk);
    chk("no early write", 0, wv);
    chk("not full", 0, sfull);
    slow <= 1'b1;
    @(posedge clk);
    sg <= 1'b1;
    @(posedge clk);
    @(posedge clk);
    sg <= 1'b0;
    for (int k = 0; k < 60 && buf_model_i.n_wr < 2; k++) @(negedge clk);
    chk("writes", 2, buf_model_i.n_wr);
    chk("first addr", 32'h0000_0100, buf_model_i.log_addr[0]);
    chk("first", 32'hAAAA_AAAA, buf_model_i.log_data[0]);
    chk("second", 32'hBBBB_0000, buf_model_i.log_data[1]);
    slow <= 1'b0;
    repeat (3) @(negedge clk);
    ld(32'h0000_0100, 6'h05, 1'b1, 1'b0, 1'b0, 1'b0);
    chk("buffer fwd", 32'hBBBB_AAAA, fwd);
    chk("buffer hit", {1'b1, 4'hF, 1'b0}, {fv, fbe, lmo});
  endtask

  // Four ungraduated stores fill the queue; a fifth push is refused
  task automatic full_queue;
    @(posedge clk);
    {sv, sa, sb, ss} <= {1'b1, 32'h0000_0500, 4'hF, 6'h10};
    repeat (4) @(posedge clk) ss <= ss + 6'h01;
    @(posedge clk);
    sv <= 1'b0;
    @(negedge clk);
    chk("queue full", 1, sfull);
  endtask

  initial begin
    repeat (20000) @(posedge clk);
    n_mismatch++;
    conclude();
  end

  initial begin
    repeat (4) @(posedge clk);
    rst_n <= 1'b1;
    br_case(1'b1, 1'b1, 1'b0, 3);
    br_case(1'b1, 1'b1, 1'b1, 3);
    br_case(1'b1, 1'b0, 1'b0, 12);
    br_case(1'b0, 1'b1, 1'b0, 0);
    mispredict(1'b0, 32'h0000_2000, 12);
    mispredict(1'b1, 32'h0000_1000, 14);
    miss_wait(1'b0);
    miss_wait(1'b1);
    early_use();
    prefetch();
    stores();
    full_queue();
    conclude();
  end
endmodule
